//--- hw/qodr_defs.svh
// Constants shared by both ends of the quad output and dual I/O read link.
`ifndef QODR_DEFS_SVH
`define QODR_DEFS_SVH

// ==========================================================================
// Opcodes
`define QODR_OP_QUAD_READ 8'h6B
`define QODR_OP_QUAD_READ_4B 8'h6C
`define QODR_OP_DUAL_READ 8'hBB
`define QODR_OP_DUAL_READ_4B 8'hBC

// ==========================================================================
// Configuration register 1 fields
`define QODR_CR1_QUAD_BIT 1
`define QODR_CR1_LC_MSB 7
`define QODR_CR1_LC_LSB 6

// ==========================================================================
// Phase lengths in serial clocks, and the mode nibble that keeps continuous read
`define QODR_OPCODE_CLKS 6'h08
`define QODR_MODE_CLKS 6'h04
`define QODR_MODE_CONT 4'hA
`define QODR_DUMMY_LC0 6'h04
`define QODR_DUMMY_LC1 6'h04
`define QODR_DUMMY_LC2 6'h05
`define QODR_DUMMY_LC3 6'h00

// ==========================================================================
// Sizes and host timing in mclk cycles
`define QODR_MEM_AW 10
`define QODR_SCK_HALF 4
`define QODR_GAP_CLKS 6'h10

`endif

//--- hw/qodr_pkg.sv
// Types shared by both ends of the read link.
`default_nettype none

package qodr_pkg;

    typedef enum logic [2:0] {
        ph_idle = 3'b000,
        ph_cmd = 3'b001,
        ph_addr = 3'b010,
        ph_mode = 3'b011,
        ph_dummy = 3'b100,
        ph_data = 3'b101,
        ph_skip = 3'b110
    } qodr_phase_t;

endpackage

`default_nettype wire

//--- hw/qodr_if.sv
// Serial link between the host controller and the flash end.
`default_nettype none

interface qodr_if;
    logic cs_n;
    logic sck;
    logic [3:0] host_io_o;
    logic [3:0] host_io_oe;
    logic [3:0] dev_io_o;
    logic [3:0] dev_io_oe;
    logic [3:0] io;

    // Undriven lines float high, as with a weak pull-up.
    assign io = (host_io_oe & host_io_o) | (dev_io_oe & dev_io_o) | ~(host_io_oe | dev_io_oe);

    modport host (
        output cs_n,
        output sck,
        output host_io_o,
        output host_io_oe,
        input io
    );

    modport flash (
        input cs_n,
        input sck,
        input io,
        output dev_io_o,
        output dev_io_oe
    );
endinterface

`default_nettype wire

//--- hw/qodr_sync.sv
// Two flip-flop synchroniser for link pins.
`default_nettype none

module qodr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge mclk) begin
        if (rst) begin
            meta <= INIT;
            q <= INIT;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

`default_nettype wire

//--- hw/qodr_flash.sv
// Flash end: quad output read and dual I/O read with continuous read mode.
`default_nettype none
`include "qodr_defs.svh"

// ==========================================================================
// How it works
// - Quad read: 6Bh short/extended, 6Ch four-byte address.
// - Quad data: nibble per clock on falling edge.
// - Quad dummy cycles ignore all four lines.
// - Start at any byte, increment per byte.
// - Address wraps past top to zero.
// - Quad commands need configuration quad bit set.
// - Dual read: BBh short/extended, BCh four-byte address.
// - Dual address two bits per rising edge.
// - High-performance variant: no mode cycles.
// - Enhanced variant: four mode clocks before latency.
// - Mode nibble A: next frame skips opcode.
// - Only mode bits 7 to 4 matter.
// - Other mode value: leave continuous at deselect.
// - Short frame without valid command exits continuous.
// - Host releases lines before first data fall.
// - Dual data two bits per falling edge.
// - Host keeps select during mode and dummy.
// - Dual dummy count from latency code field.
// - Opcode serial on line 0, MSB first.
// - Extended bit selects four-byte; else bank high.
// - Deselect ends read; no length limit.
module qodr_flash
    import qodr_pkg::*;
#(
    parameter int MEM_AW = `QODR_MEM_AW
) (
    input wire logic mclk,
    input wire logic rst,
    qodr_if.flash lnk,
    input wire logic [7:0] configuration_register_1,
    input wire logic extended_address_bit,
    input wire logic [7:0] bank_addr,
    input wire logic enhanced_perf,
    input wire logic mem_we,
    input wire logic [MEM_AW-1:0] mem_waddr,
    input wire logic [7:0] mem_wdata,
    output logic cont_mode
);

    // ======================================================================
    // Helpers
    function automatic logic [5:0] addr_clocks(input logic four, input logic two_lane);
        logic [5:0] bits;
        bits = four ? 6'h20 : 6'h18;
        addr_clocks = two_lane ? (bits >> 1) : bits;
    endfunction

    function automatic logic [5:0] lc_dummy(input logic [1:0] lc);
        unique case (lc)
            2'h0: lc_dummy = `QODR_DUMMY_LC0;
            2'h1: lc_dummy = `QODR_DUMMY_LC1;
            2'h2: lc_dummy = `QODR_DUMMY_LC2;
            2'h3: lc_dummy = `QODR_DUMMY_LC3;
        endcase
    endfunction

    // ======================================================================
    // Pin sampling and edge detection
    logic [5:0] pins_s;
    logic cs_s;
    logic sck_s;
    logic [3:0] io_s;
    logic cs_d;
    logic sck_d;
    logic rise;
    logic fall;
    logic cs_rise;
    logic cs_fall;

    qodr_sync #(
        .W(6),
        .INIT(6'h20)
    ) u_sync (
        .mclk(mclk),
        .rst(rst),
        .d({lnk.cs_n, lnk.sck, lnk.io}),
        .q(pins_s)
    );

    assign cs_s = pins_s[5];
    assign sck_s = pins_s[4];
    assign io_s = pins_s[3:0];

    always_ff @(posedge mclk) begin
        if (rst) begin
            cs_d <= 1'b1;
            sck_d <= 1'b0;
        end else begin
            cs_d <= cs_s;
            sck_d <= sck_s;
        end
    end

    assign rise = sck_s && !sck_d && !cs_s;
    assign fall = !sck_s && sck_d && !cs_s;
    assign cs_rise = cs_s && !cs_d;
    assign cs_fall = !cs_s && cs_d;

    // ======================================================================
    // Command, address, mode and dummy sequencing on rising edges
    qodr_phase_t phase;
    logic [5:0] cnt;
    logic [31:0] sh_in;
    logic two_lane;
    logic four_byte;
    logic mode_a;
    logic [31:0] next_sh1;
    logic [31:0] next_sh2;
    logic [31:0] next_sh;
    logic [31:0] full_addr;
    logic [7:0] op_rx;
    logic op_quad;
    logic op_dual;
    logic [5:0] lat;

    assign next_sh1 = {sh_in[30:0], io_s[0]};
    assign next_sh2 = {sh_in[29:0], io_s[1:0]};
    assign next_sh = two_lane ? next_sh2 : next_sh1;
    assign full_addr = four_byte ? next_sh : {bank_addr, next_sh[23:0]};
    assign op_rx = next_sh1[7:0];
    assign op_quad = (op_rx == `QODR_OP_QUAD_READ) || (op_rx == `QODR_OP_QUAD_READ_4B);
    assign op_dual = (op_rx == `QODR_OP_DUAL_READ) || (op_rx == `QODR_OP_DUAL_READ_4B);
    assign lat = lc_dummy(configuration_register_1[`QODR_CR1_LC_MSB:`QODR_CR1_LC_LSB]);

    always_ff @(posedge mclk) begin
        if (rst) begin
            phase <= ph_idle;
            cnt <= 6'h00;
            sh_in <= 32'h0000_0000;
            two_lane <= 1'b0;
            four_byte <= 1'b0;
            mode_a <= 1'b0;
        end else if (cs_rise) begin
            phase <= ph_idle;
        end else if (cs_fall) begin
            mode_a <= 1'b0;
            sh_in <= 32'h0000_0000;
            if (cont_mode) begin
                phase <= ph_addr;
                two_lane <= 1'b1;
                cnt <= addr_clocks(four_byte, 1'b1);
            end else begin
                phase <= ph_cmd;
                cnt <= `QODR_OPCODE_CLKS;
            end
        end else if (rise) begin
            unique case (phase)
                ph_cmd: begin
                    sh_in <= next_sh1;
                    cnt <= cnt - 6'h01;
                    if (cnt == 6'h01) begin
                        if (op_quad && configuration_register_1[`QODR_CR1_QUAD_BIT]) begin
                            phase <= ph_addr;
                            two_lane <= 1'b0;
                            four_byte <= extended_address_bit || (op_rx == `QODR_OP_QUAD_READ_4B);
                            cnt <= addr_clocks(extended_address_bit || (op_rx == `QODR_OP_QUAD_READ_4B), 1'b0);
                        end else if (op_dual) begin
                            phase <= ph_addr;
                            two_lane <= 1'b1;
                            four_byte <= extended_address_bit || (op_rx == `QODR_OP_DUAL_READ_4B);
                            cnt <= addr_clocks(extended_address_bit || (op_rx == `QODR_OP_DUAL_READ_4B), 1'b1);
                        end else begin
                            phase <= ph_skip;
                        end
                    end
                end
                ph_addr: begin
                    sh_in <= next_sh;
                    cnt <= cnt - 6'h01;
                    if (cnt == 6'h01) begin
                        if (two_lane && enhanced_perf) begin
                            phase <= ph_mode;
                            cnt <= `QODR_MODE_CLKS;
                        end else begin
                            phase <= (lat == 6'h00) ? ph_data : ph_dummy;
                            cnt <= lat;
                        end
                    end
                end
                ph_mode: begin
                    sh_in <= next_sh2;
                    cnt <= cnt - 6'h01;
                    if (cnt == 6'h01) begin
                        // Low nibble of the mode byte is never looked at.
                        mode_a <= (next_sh2[7:4] == `QODR_MODE_CONT);
                        phase <= (lat == 6'h00) ? ph_data : ph_dummy;
                        cnt <= lat;
                    end
                end
                ph_dummy: begin
                    // Lines are not sampled here, so a floating bus is harmless.
                    cnt <= cnt - 6'h01;
                    if (cnt == 6'h01) begin
                        phase <= ph_data;
                    end
                end
                ph_idle, ph_data, ph_skip: begin
                end
                default: begin
                    phase <= ph_skip;
                end
            endcase
        end
    end

    // ======================================================================
    // Continuous read mode: decided only when select goes high
    always_ff @(posedge mclk) begin
        if (rst) begin
            cont_mode <= 1'b0;
        end else if (cs_rise) begin
            // Frames cut short before data, including the short invalid ones, drop the mode.
            cont_mode <= (phase == ph_data) && mode_a;
        end
    end

    // ======================================================================
    // Array and read address
    logic [7:0] mem [0:(2**MEM_AW)-1];
    logic [MEM_AW-1:0] rd_addr;
    logic [7:0] cur_byte;
    logic [7:0] out_sh;
    logic [1:0] chunk;

    always_ff @(posedge mclk) begin
        if (mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

    assign cur_byte = mem[rd_addr];

    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_addr <= '0;
        end else if (rise && phase == ph_addr && cnt == 6'h01) begin
            rd_addr <= full_addr[MEM_AW-1:0];
        end else if (fall && phase == ph_data && chunk == 2'h0) begin
            // Natural overflow of the counter gives the wrap to zero.
            rd_addr <= rd_addr + MEM_AW'(1);
        end
    end

    // ======================================================================
    // Data output on falling edges
    always_ff @(posedge mclk) begin
        if (rst || cs_rise) begin
            lnk.dev_io_oe <= 4'h0;
            lnk.dev_io_o <= 4'h0;
            out_sh <= 8'h00;
            chunk <= 2'h0;
        end else if (fall && phase == ph_data) begin
            lnk.dev_io_oe <= two_lane ? 4'h3 : 4'hF;
            if (chunk == 2'h0) begin
                lnk.dev_io_o <= two_lane ? {2'h0, cur_byte[7:6]} : cur_byte[7:4];
                out_sh <= two_lane ? {cur_byte[5:0], 2'h0} : {cur_byte[3:0], 4'h0};
                chunk <= two_lane ? 2'h3 : 2'h1;
            end else begin
                lnk.dev_io_o <= two_lane ? {2'h0, out_sh[7:6]} : out_sh[7:4];
                out_sh <= two_lane ? {out_sh[5:0], 2'h0} : {out_sh[3:0], 4'h0};
                chunk <= chunk - 2'h1;
            end
        end
    end

endmodule

`default_nettype wire

//--- hw/qodr_host.sv
// Host end: issues quad output and dual I/O reads and collects the data bytes.
`default_nettype none
`include "qodr_defs.svh"

module qodr_host
    import qodr_pkg::*;
#(
    parameter int HALF = `QODR_SCK_HALF
) (
    input wire logic mclk,
    input wire logic rst,
    qodr_if.host lnk,
    input wire logic req,
    input wire logic [7:0] opcode,
    input wire logic [31:0] addr,
    input wire logic four_byte,
    input wire logic two_lane,
    input wire logic send_mode,
    input wire logic skip_opcode,
    input wire logic [7:0] mode_byte,
    input wire logic [5:0] dummy_clks,
    input wire logic [15:0] nbytes,
    output logic busy,
    output logic rd_valid,
    output logic [7:0] rd_data
);

    // ======================================================================
    // Serial clock divider
    qodr_phase_t phase;
    logic [7:0] div;
    logic tick;
    logic kick;
    logic fall_step;
    logic clk_run;

    assign tick = (div == 8'(HALF - 1));
    assign fall_step = kick || (tick && lnk.sck);
    assign clk_run = !kick && (phase != ph_idle) && (phase != ph_skip);

    always_ff @(posedge mclk) begin
        if (rst || !clk_run) begin
            div <= 8'h00;
            lnk.sck <= 1'b0;
        end else if (tick) begin
            div <= 8'h00;
            lnk.sck <= ~lnk.sck;
        end else begin
            div <= div + 8'h01;
        end
    end

    // ======================================================================
    // Frame sequencing; lines change only at falling steps
    logic [3:0] io_s;
    logic [5:0] cnt;
    logic [47:0] sh;
    logic t2;
    logic send_m;
    logic [5:0] dcl;
    logic [15:0] bytes_left;
    logic [1:0] chunk;
    logic [7:0] rx;
    logic [7:0] rx_next;
    logic first;
    logic [5:0] addr_len;
    qodr_phase_t lat_phase;

    qodr_sync #(
        .W(4),
        .INIT(4'h0)
    ) u_sync (
        .mclk(mclk),
        .rst(rst),
        .d(lnk.io),
        .q(io_s)
    );

    assign addr_len = t2 ? (four_byte ? 6'h10 : 6'h0C) : (four_byte ? 6'h20 : 6'h18);
    assign lat_phase = (dcl == 6'h00) ? ph_data : ph_dummy;
    assign rx_next = t2 ? {rx[5:0], io_s[1:0]} : {rx[3:0], io_s};

    always_ff @(posedge mclk) begin
        if (rst) begin
            phase <= ph_idle;
            lnk.cs_n <= 1'b1;
            lnk.host_io_o <= 4'h0;
            lnk.host_io_oe <= 4'h0;
            busy <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= 8'h00;
            kick <= 1'b0;
            cnt <= 6'h00;
            sh <= 48'h0000_0000_0000;
            t2 <= 1'b0;
            send_m <= 1'b0;
            dcl <= 6'h00;
            bytes_left <= 16'h0000;
            chunk <= 2'h0;
            rx <= 8'h00;
            first <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            kick <= 1'b0;
            if (phase == ph_idle) begin
                if (req) begin
                    lnk.cs_n <= 1'b0;
                    busy <= 1'b1;
                    kick <= 1'b1;
                    t2 <= two_lane;
                    send_m <= send_mode;
                    dcl <= dummy_clks;
                    bytes_left <= nbytes;
                    chunk <= 2'h0;
                    first <= 1'b1;
                    // The mode byte must sit right behind the last address bit for either address length.
                    if (skip_opcode) begin
                        sh <= four_byte ? {addr, mode_byte, 8'h00} : {addr[23:0], mode_byte, 16'h0000};
                        phase <= ph_addr;
                        cnt <= two_lane ? (four_byte ? 6'h10 : 6'h0C) : (four_byte ? 6'h20 : 6'h18);
                    end else begin
                        sh <= four_byte ? {opcode, addr, mode_byte} : {opcode, addr[23:0], mode_byte, 8'h00};
                        phase <= ph_cmd;
                        cnt <= `QODR_OPCODE_CLKS;
                    end
                end
            end else if (phase == ph_skip) begin
                cnt <= cnt - 6'h01;
                if (cnt == 6'h01) begin
                    phase <= ph_idle;
                    busy <= 1'b0;
                end
            end else if (fall_step) begin
                cnt <= cnt - 6'h01;
                if (phase == ph_cmd) begin
                    lnk.host_io_o <= {3'h0, sh[47]};
                    lnk.host_io_oe <= 4'h1;
                    sh <= {sh[46:0], 1'b0};
                    if (cnt == 6'h01) begin
                        phase <= ph_addr;
                        cnt <= addr_len;
                    end
                end else if (phase == ph_addr) begin
                    lnk.host_io_o <= t2 ? {2'h0, sh[47:46]} : {3'h0, sh[47]};
                    lnk.host_io_oe <= t2 ? 4'h3 : 4'h1;
                    sh <= t2 ? {sh[45:0], 2'h0} : {sh[46:0], 1'b0};
                    if (cnt == 6'h01) begin
                        phase <= send_m ? ph_mode : lat_phase;
                        cnt <= send_m ? `QODR_MODE_CLKS : dcl;
                    end
                end else if (phase == ph_mode) begin
                    lnk.host_io_o <= {2'h0, sh[47:46]};
                    lnk.host_io_oe <= 4'h3;
                    sh <= {sh[45:0], 2'h0};
                    if (cnt == 6'h01) begin
                        phase <= lat_phase;
                        cnt <= dcl;
                    end
                end else if (phase == ph_dummy) begin
                    lnk.host_io_oe <= 4'h0;
                    if (cnt == 6'h01) begin
                        phase <= ph_data;
                    end
                end else begin
                    lnk.host_io_oe <= 4'h0;
                    first <= 1'b0;
                    if (!first) begin
                        rx <= rx_next;
                        chunk <= chunk + 2'h1;
                        if (chunk == (t2 ? 2'h3 : 2'h1)) begin
                            chunk <= 2'h0;
                            rd_valid <= 1'b1;
                            rd_data <= rx_next;
                            bytes_left <= bytes_left - 16'h0001;
                            if (bytes_left == 16'h0001) begin
                                // Select rises only after whole data, never in mode or dummy.
                                lnk.cs_n <= 1'b1;
                                phase <= ph_skip;
                                cnt <= `QODR_GAP_CLKS;
                            end
                        end
                    end
                end
            end
        end
    end

endmodule

`default_nettype wire

//--- dv/qodr_checker.sv
// Concurrent checks on the serial link between the host and flash ends.
`default_nettype none

module qodr_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic [3:0] host_io_o,
    input wire logic [3:0] host_io_oe,
    input wire logic [3:0] dev_io_o,
    input wire logic [3:0] dev_io_oe,
    input wire logic [3:0] io
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] rise_cnt;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // =========================================================================
    // Helper logic
    always_ff @(posedge mclk) begin
        if (rst || cs_n) begin
            rise_cnt <= 4'h0;
        end else if ($rose(sck) && rise_cnt != 4'hf) begin
            rise_cnt <= rise_cnt + 4'h1;
        end
    end

    sequence s_deselected;
        cs_n [*6];
    endsequence

    sequence s_sck_high;
        sck [*4] ##1 !sck;
    endsequence

    // =========================================================================
    // Assertions
    a_dev_release_deselect: assert property (s_deselected |-> dev_io_oe == 4'h0)
        else $error("flash drives while deselected");
    a_sck_half_period: assert property ($rose(sck) |-> s_sck_high)
        else $error("serial clock high phase wrong");
    a_sck_only_selected: assert property (sck |-> !cs_n)
        else $error("serial clock high while deselected");
    a_host_stable_rise: assert property ($rose(sck) |-> $stable(host_io_o) && $stable(host_io_oe))
        else $error("host lines change at rising edge");
    a_no_line_fight: assert property ((host_io_oe & dev_io_oe) == 4'h0)
        else $error("both ends drive one line");
    a_dev_change_low: assert property (dev_io_oe != 4'h0 && $changed(dev_io_o) |-> !sck)
        else $error("flash data changes while clock high");
    a_dev_lane_set: assert property (dev_io_oe inside {4'h0, 4'h3, 4'hf})
        else $error("flash drives an odd lane set");
    a_host_lane_set: assert property (host_io_oe inside {4'h0, 4'h1, 4'h3})
        else $error("host drives an odd lane set");
    a_cmd_quiet: assert property (!cs_n && rise_cnt < 4'h8 |-> dev_io_oe == 4'h0)
        else $error("flash drives during opcode clocks");
    a_dev_lines_seen: assert property (dev_io_oe != 4'h0 |-> (io & dev_io_oe) == (dev_io_o & dev_io_oe))
        else $error("flash data not seen on the lines");
endmodule

`default_nettype wire

//--- dv/test_quad_output_dual_io_read.sv
// Self-checking bench for the quad output and dual I/O read link.
`default_nettype none
`include "qodr_defs.svh"

`define CHK(nm, e, g) begin total_checks++; if ((e) !== (g)) begin mismatches++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module test_quad_output_dual_io_read
    import qodr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, rst, ext, enh, we, cont, req, fb, two, smode, skip, busy, rd_valid;
    logic [7:0] cfg_reg, bank, wdata, op, mb, rd_data;
    logic [9:0] waddr;
    logic [31:0] addr;
    logic [5:0] dclk;
    logic [15:0] nb;
    logic [7:0] mem [0:1023];
    logic [7:0] exp_q [$];
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;

    qodr_if lnk ();
    qodr_flash qodr_flash_inst (.mclk(mclk), .rst(rst), .lnk(lnk), .configuration_register_1(cfg_reg),
        .extended_address_bit(ext), .bank_addr(bank), .enhanced_perf(enh), .mem_we(we),
        .mem_waddr(waddr), .mem_wdata(wdata), .cont_mode(cont));
    qodr_host qodr_host_inst (.mclk(mclk), .rst(rst), .lnk(lnk), .req(req), .opcode(op), .addr(addr),
        .four_byte(fb), .two_lane(two), .send_mode(smode), .skip_opcode(skip), .mode_byte(mb),
        .dummy_clks(dclk), .nbytes(nb), .busy(busy), .rd_valid(rd_valid), .rd_data(rd_data));
    qodr_checker qodr_checker_inst (.mclk(mclk), .rst(rst), .cs_n(lnk.cs_n), .sck(lnk.sck),
        .host_io_o(lnk.host_io_o), .host_io_oe(lnk.host_io_oe), .dev_io_o(lnk.dev_io_o),
        .dev_io_oe(lnk.dev_io_oe), .io(lnk.io));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic stop_test;
        if (mismatches == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            stop_test();
        end
    end

    // =========================================================================
    // Byte monitor: each byte seen is matched against the oldest note.
    always @(negedge mclk) begin
        logic [7:0] e_b;
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHK("spare byte", 1'b0, 1'b1)
            end else begin
                e_b = exp_q.pop_front();
                `CHK("read byte", e_b, rd_data)
            end
        end
    end

    function automatic logic [5:0] dummy(input logic [1:0] c);
        return c == 2'b00 ? `QODR_DUMMY_LC0 : c == 2'b01 ? `QODR_DUMMY_LC1 :
            c == 2'b10 ? `QODR_DUMMY_LC2 : `QODR_DUMMY_LC3;
    endfunction

    // One read frame; a quad read with the quad bit clear returns the idle line level.
    task automatic frame(input logic [7:0] o, input logic [31:0] a, input logic f, t, s, k,
                         input logic [7:0] m, input logic [1:0] lat, input logic [15:0] n, input logic qen);
        int i;
        for (i = 0; i < n; i++) begin
            exp_q.push_back((!qen && !t) ? 8'hff : mem[10'(a + 32'(i))]);
        end
        @(posedge mclk);
        cfg_reg <= {lat, 4'h0, qen, 1'b0};
        op <= o;
        addr <= a;
        fb <= f;
        two <= t;
        smode <= s;
        skip <= k;
        mb <= m;
        dclk <= dummy(lat);
        nb <= n;
        req <= 1'b1;
        @(posedge mclk);
        req <= 1'b0;
        i = 0;
        while (busy !== 1'b1 && i < 10) begin
            @(negedge mclk);
            i++;
        end
        while (busy !== 1'b0) begin
            @(negedge mclk);
        end
    endtask

    initial begin
        int i;
        {rst, ext, enh, we, req, fb, two, smode, skip} = 9'h1_00;
        {cfg_reg, bank, wdata, op, mb} = 40'h00_0000_0000;
        waddr = 10'h000;
        addr = 32'h0000_0000;
        dclk = 6'h00;
        nb = 16'h0001;
        void'($urandom(54932));
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        for (i = 0; i < 1024; i++) begin
            mem[i] = 8'($urandom);
            we <= 1'b1;
            waddr <= 10'(i);
            wdata <= mem[i];
            @(posedge mclk);
        end
        we <= 1'b0;
        bank <= 8'($urandom);
        frame(`QODR_OP_QUAD_READ, $urandom & 32'h00ff_ffff, 0, 0, 0, 0, 8'h00, 2'b00, 5, 1);
        frame(`QODR_OP_QUAD_READ_4B, 32'h0000_03fe, 1, 0, 0, 0, 8'h00, 2'b01, 4, 1);
        @(posedge mclk);
        ext <= 1'b1;
        frame(`QODR_OP_QUAD_READ, $urandom, 1, 0, 0, 0, 8'h00, 2'b11, 3, 1);
        frame(`QODR_OP_QUAD_READ, $urandom, 1, 0, 0, 0, 8'h00, 2'b00, 2, 0);
        @(posedge mclk);
        {ext, enh} <= 2'b01;
        frame(`QODR_OP_DUAL_READ, $urandom & 32'h00ff_ffff, 0, 1, 1, 0, 8'ha5, 2'b10, 3, 1);
        `CHK("cont after A5", 1'b1, cont)
        frame(8'h00, $urandom & 32'h00ff_ffff, 0, 1, 1, 1, 8'ha3, 2'($urandom), 3, 1);
        `CHK("cont after A3", 1'b1, cont)
        frame(8'h00, 32'h0000_03ff, 0, 1, 1, 1, 8'h5a, 2'($urandom), 2, 1);
        `CHK("cont after 5A", 1'b0, cont)
        frame(`QODR_OP_DUAL_READ_4B, $urandom, 1, 1, 1, 0, 8'h00, 2'b00, 3, 1);
        `CHK("cont after 00", 1'b0, cont)
        @(posedge mclk);
        enh <= 1'b0;
        frame(`QODR_OP_DUAL_READ, $urandom & 32'h00ff_ffff, 0, 1, 0, 0, 8'ha0, 2'b01, 3, 1);
        `CHK("cont high perf", 1'b0, cont)
        repeat (4) @(negedge mclk);
        `CHK("bytes missing", 0, exp_q.size())
        stop_test();
    end
endmodule

`default_nettype wire
